/* File: core/lrs_pkg.sv */
// ============================================================
// shared constants and carriers for the link receive block
package lrs_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0] LRS_OFS_MAX_INFO   = 8'h00;
	localparam logic [7:0] LRS_OFS_POOL       = 8'h04;
	localparam logic [7:0] LRS_OFS_LINK_MODE  = 8'h08;
	localparam logic [7:0] LRS_OFS_QUEUE_HEAD = 8'h0C;
	localparam logic [7:0] LRS_OFS_TX_NEXT    = 8'h10;
	localparam logic [7:0] LRS_OFS_TX_ACK     = 8'h14;
	localparam logic [7:0] LRS_OFS_NEXT_LINK  = 8'h18;
	localparam logic [7:0] LRS_OFS_COUNTERS   = 8'h1C;
	localparam logic [7:0] LRS_OFS_LIMITS     = 8'h20;
	localparam logic [7:0] LRS_OFS_OPTIONS2   = 8'h24;
	localparam logic [7:0] LRS_OFS_ERR_MASKS  = 8'h28;
	localparam logic [7:0] LRS_OFS_COMMAND    = 8'h2C;
	localparam logic [7:0] LRS_OFS_RX_STATUS  = 8'h30;
	// field positions
	localparam int LRS_EAV_BIT      = 15;
	localparam int LRS_NONPROTO_BIT = 0;
	localparam int LRS_MULTIBUF_BIT = 1;
	localparam int LRS_FINAL_BIT    = 2;
	localparam int LRS_BUSY_BIT     = 3;
	localparam int LRS_CMD_SEND_BIT = 0;
	localparam int LRS_CMD_ASSN_BIT = 1;
	localparam int LRS_CMD_RELD_BIT = 2;
	// reset values and frame size figures
	localparam logic [14:0] LRS_MAX_INFO_RST = 15'h0104;
	localparam logic [7:0]  LRS_LIMIT_RST    = 8'h00;
	localparam logic [15:0] LRS_MIN_UNNUM    = 16'h0005;
	localparam logic [15:0] LRS_MIN_NUM      = 16'h0006;
	localparam logic [15:0] LRS_MIN_NONPROTO = 16'h0005;
	localparam logic [15:0] LRS_SPLIT_MARGIN = 16'h0002;

	// receive octet stream from the deframer
	typedef struct packed {
		logic       start;       // opening flag seen
		logic       byte_valid;  // one octet between flags
		logic [7:0] data;
		logic       frame_end;   // closing flag seen
		logic       numbered;    // i or s frame, valid with start
		logic [7:0] err;         // error classes, valid with frame_end
	} lrs_rx_t;

	// buffer write stream towards memory
	typedef struct packed {
		logic       valid;
		logic       fetch;       // this byte opens a fresh buffer
		logic [7:0] data;
	} lrs_wr_t;

	// frame verdict, one pulse per frame
	typedef struct packed {
		logic        done;
		logic        accepted;
		logic        short_f;
		logic        long_f;
		logic        err_rej;
		logic [15:0] count;
	} lrs_frm_t;

	typedef enum logic [1:0] {LRS_IDLE, LRS_RECV, LRS_FLUSH} lrs_rx_st_t;

	// whole state of the block
	typedef struct packed {
		logic [14:0] max_info_length_value;
		logic [12:0] pool;
		logic        error_accept_valid;
		logic        nonproto;
		logic        multibuf;
		logic        final_link_in_queue;
		logic        local_busy;
		logic [31:0] queue_head;
		logic [31:0] tx_next;
		logic [31:0] tx_ack;
		logic [31:0] next_link;
		logic [15:0] tx_len;
		logic [7:0]  sent_reject_count;
		logic [7:0]  sent_not_ready_count;
		logic [7:0]  rej_staged;
		logic [7:0]  rnr_staged;
		logic [7:0]  sent_reject_limit;
		logic [7:0]  sent_not_ready_limit;
		logic        stats_en;
		logic [7:0]  proto_mask;
		logic [7:0]  nonproto_mask;
		lrs_rx_st_t  rx_st;
		logic        numbered;
		logic        long_f;
		logic [7:0]  err;
		logic [15:0] oct_cnt;
		logic [15:0] buf_cnt;
		logic [7:0]  hold0;
		logic [7:0]  hold1;
		logic [1:0]  hold_n;
		lrs_wr_t     wr;
		lrs_frm_t    frm;
		logic        iq_post;
		logic [1:0]  iq_code;
		logic [31:0] prdata;
		logic        pslverr;
	} lrs_state_t;
endpackage

/* File: core/lrs_link_rx.sv */
`timescale 1ns/100ps
// Overview of operation
// R01 - length field is low 15 bits; zero blocks data; here only single buffer blocks, protocol keeps 5 or 6 octets, split keeps all
// R02 - protocol limit is max info field octets
// R03 - protocol minimum 5 unnumbered, 6 numbered octets
// R04 - frames below minimum size are discarded
// R05 - overlong frame flagged long, excess octets dropped
// R06 - single buffer: limit bounds buffer, minimum 5
// R07 - split buffer: fill limit minus two, last full
// R08 - host programs even limit 6 to 32K-2
// R09 - host supplies buffers of at least 6 bytes
// R10 - transmit length taken from descriptor, unchecked
// R11 - low 13 pool bits select receive pool
// R12 - host sizes pool buffers for largest limit
// R13 - error accept bit gates masked erroneous frames
// R14 - host changes limit and pool under local busy
// R15 - send request loads transmit next pointer
// R16 - acknowledge pointer loaded then advanced on acks
// R17 - next link pointer chains while not final
// R18 - reject sent counter counts down, posts, reloads
// R19 - not ready sent counter counts down, posts, reloads
// R20 - statistics counters move only when enabled; here the assign command loads them even when disabled
// R21 - new threshold only taken at next expiry
module lrs_link_rx (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// receive side
	input  lrs_pkg::lrs_rx_t       rx_in,
	output lrs_pkg::lrs_wr_t       buf_wr,
	output lrs_pkg::lrs_frm_t      frame_res,
	output logic [12:0]            rx_pool,
	// transmit queue events
	input  wire logic              tx_advance,
	input  wire logic [31:0]       tx_advance_ptr,
	input  wire logic              tx_acked,
	input  wire logic [31:0]       tx_acked_ptr,
	input  wire logic              tx_desc_load,
	input  wire logic [15:0]       tx_desc_len,
	output logic [31:0]            tx_next_ptr,
	output logic [31:0]            tx_ack_ptr,
	output logic [15:0]            tx_len,
	output logic                   next_link_valid,
	output logic [31:0]            next_link_addr,
	// supervisory frame statistics
	input  wire logic              rej_sent,
	input  wire logic              rnr_sent,
	output logic                   iq_post,
	output logic [1:0]             iq_code
);
	import lrs_pkg::*;

	lrs_state_t s_q;  // registered state
	lrs_state_t s_d;  // next state

	// ============================================================
	// byte lane merge for writable registers
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	// ============================================================
	// next state
	always_comb begin
		logic [31:0] rd_v;    // read mux result
		logic        hit;     // address decodes to a register
		logic [31:0] wv;      // merged write value
		logic [31:0] old_v;   // current value of addressed word
		logic        wr_en;   // write takes effect this edge
		logic [7:0]  ofs;     // word aligned offset
		logic [15:0] minsz;   // minimum frame for this link
		logic [16:0] limit;   // most octets kept between flags
		logic        split;   // split buffer mode
		logic        emit;    // one held octet goes to memory
		logic [7:0]  emit_b;
		logic        allow_split; // buffer change allowed now
		logic [15:0] oct;
		logic        is_err;
		logic        mask_ok;
		rd_v = 32'h0000_0000;
		hit = 1'b1;
		wv = 32'h0000_0000;
		old_v = 32'h0000_0000;
		wr_en = 1'b0;
		ofs = {paddr[7:2], 2'b00};
		minsz = LRS_MIN_UNNUM;
		limit = 17'h0_0000;
		split = 1'b0;
		emit = 1'b0;
		emit_b = 8'h00;
		allow_split = 1'b0;
		oct = 16'h0000;
		is_err = 1'b0;
		mask_ok = 1'b0;
		s_d = s_q;
		// pulses last one cycle
		s_d.wr.valid = 1'b0;
		s_d.wr.fetch = 1'b0;
		s_d.frm.done = 1'b0;
		s_d.iq_post = 1'b0;
		s_d.iq_code = 2'b00;

		// read mux; upper address bits must be zero to hit
		case (ofs)
			LRS_OFS_MAX_INFO:   rd_v = {17'h0_0000, s_q.max_info_length_value};
			LRS_OFS_POOL:       rd_v = {16'h0000, s_q.error_accept_valid,
				2'b00, s_q.pool}; // [R11]
			LRS_OFS_LINK_MODE:  rd_v = {28'h000_0000, s_q.local_busy,
				s_q.final_link_in_queue, s_q.multibuf, s_q.nonproto};
			LRS_OFS_QUEUE_HEAD: rd_v = s_q.queue_head;
			LRS_OFS_TX_NEXT:    rd_v = s_q.tx_next;
			LRS_OFS_TX_ACK:     rd_v = s_q.tx_ack;
			LRS_OFS_NEXT_LINK:  rd_v = s_q.next_link;
			LRS_OFS_COUNTERS:   rd_v = {16'h0000, s_q.sent_not_ready_count,
				s_q.sent_reject_count};
			LRS_OFS_LIMITS:     rd_v = {s_q.sent_not_ready_limit,
				s_q.sent_reject_limit, s_q.rnr_staged, s_q.rej_staged};
			LRS_OFS_OPTIONS2:   rd_v = {31'h0000_0000, s_q.stats_en};
			LRS_OFS_ERR_MASKS:  rd_v = {16'h0000, s_q.nonproto_mask,
				s_q.proto_mask};
			LRS_OFS_COMMAND:    rd_v = 32'h0000_0000;
			LRS_OFS_RX_STATUS:  rd_v = {s_q.frm.count, 12'h000, s_q.frm.err_rej,
				s_q.frm.long_f, s_q.frm.short_f, s_q.frm.accepted};
			default:            hit = 1'b0;
		endcase
		if (paddr[31:8] != 24'h00_0000) begin
			hit = 1'b0;
		end
		old_v = rd_v;

		// read data and error are caught in the setup cycle
		if (psel && !penable) begin
			s_d.prdata = hit ? rd_v : 32'h0000_0000;
			s_d.pslverr = !hit;
		end
		wr_en = psel && penable && pwrite && hit;
		wv = lane_merge(old_v, pwdata, pstrb);

		// register writes
		if (wr_en) begin
			case (ofs)
				LRS_OFS_MAX_INFO: begin
					// bit 15 is never stored, so it always reads zero
					s_d.max_info_length_value = wv[14:0]; // [R01]
				end
				LRS_OFS_POOL: begin
					s_d.pool = wv[12:0]; // [R11]
					s_d.error_accept_valid = wv[LRS_EAV_BIT];
				end
				LRS_OFS_LINK_MODE: begin
					s_d.nonproto = wv[LRS_NONPROTO_BIT];
					s_d.multibuf = wv[LRS_MULTIBUF_BIT];
					s_d.final_link_in_queue = wv[LRS_FINAL_BIT];
					s_d.local_busy = wv[LRS_BUSY_BIT];
				end
				LRS_OFS_QUEUE_HEAD: s_d.queue_head = wv;
				LRS_OFS_NEXT_LINK:  s_d.next_link = wv;
				LRS_OFS_LIMITS: begin
					// staged only; live limits move on reload
					s_d.rej_staged = wv[7:0];
					s_d.rnr_staged = wv[15:8];
				end
				LRS_OFS_OPTIONS2:  s_d.stats_en = wv[0];
				LRS_OFS_ERR_MASKS: begin
					s_d.proto_mask = wv[7:0];
					s_d.nonproto_mask = wv[15:8];
				end
				default: begin
				end
			endcase
		end

		// ============================================================
		// transmit queue pointers
		if (tx_advance) begin
			s_d.tx_next = tx_advance_ptr; // [R15]
		end
		if (tx_acked) begin
			s_d.tx_ack = tx_acked_ptr; // [R16]
		end
		if (tx_desc_load) begin
			// length used as given; the receive limit plays no part
			s_d.tx_len = tx_desc_len; // [R10]
		end
		// a send request wins over a same-cycle pointer step
		if (wr_en && ofs == LRS_OFS_COMMAND && wv[LRS_CMD_SEND_BIT]) begin
			s_d.tx_next = s_q.queue_head; // [R15]
			s_d.tx_ack = s_q.queue_head; // [R16]
		end

		// ============================================================
		// supervisory frame counters
		if (wr_en && ofs == LRS_OFS_COMMAND && wv[LRS_CMD_RELD_BIT]) begin
			// live limit changes, counters keep counting down
			s_d.sent_reject_limit = s_q.rej_staged; // [R21]
			s_d.sent_not_ready_limit = s_q.rnr_staged; // [R21]
		end
		if (wr_en && ofs == LRS_OFS_COMMAND && wv[LRS_CMD_ASSN_BIT]) begin
			s_d.sent_reject_count = s_q.sent_reject_limit; // [R18]
			s_d.sent_not_ready_count = s_q.sent_not_ready_limit; // [R19]
		end else if (s_q.stats_en) begin // [R20]
			if (rej_sent) begin
				// a count of one or zero expires on this frame
				if (s_q.sent_reject_count <= 8'h01) begin
					s_d.iq_post = 1'b1; // [R18]
					s_d.iq_code[0] = 1'b1;
					s_d.sent_reject_count = s_q.sent_reject_limit; // [R21]
				end else begin
					s_d.sent_reject_count = s_q.sent_reject_count - 8'h01;
				end
			end
			if (rnr_sent) begin
				if (s_q.sent_not_ready_count <= 8'h01) begin
					s_d.iq_post = 1'b1; // [R19]
					s_d.iq_code[1] = 1'b1;
					s_d.sent_not_ready_count = s_q.sent_not_ready_limit; // [R21]
				end else begin
					s_d.sent_not_ready_count = s_q.sent_not_ready_count
						- 8'h01;
				end
			end
		end

		// ============================================================
		// receive length checks and buffer filling
		split = s_q.nonproto && s_q.multibuf;
		if (s_q.nonproto) begin
			minsz = LRS_MIN_NONPROTO; // [R06]
		end else if (s_q.numbered) begin
			minsz = LRS_MIN_NUM; // [R03]
		end else begin
			minsz = LRS_MIN_UNNUM; // [R03]
		end
		// protocol: info field plus header and check octets
		if (s_q.nonproto) begin
			limit = {2'b00, s_q.max_info_length_value}; // [R06]
		end else begin
			limit = {2'b00, s_q.max_info_length_value} + {1'b0, minsz}; // [R02]
		end
		oct = (s_q.oct_cnt == 16'hFFFF) ? s_q.oct_cnt : s_q.oct_cnt + 16'h0001;

		case (s_q.rx_st)
			LRS_IDLE: begin
				if (rx_in.start) begin
					s_d.rx_st = LRS_RECV;
					s_d.numbered = rx_in.numbered;
					s_d.oct_cnt = 16'h0000;
					s_d.buf_cnt = 16'h0000;
					s_d.hold_n = 2'b00;
					s_d.long_f = 1'b0;
					s_d.err = 8'h00;
				end
			end
			LRS_RECV: begin
				if (rx_in.byte_valid) begin
					s_d.oct_cnt = oct;
					// split mode has no frame limit, only buffer limit
					if (!split && {1'b0, oct} > limit) begin
						s_d.long_f = 1'b1; // [R05]
					end else if (s_q.hold_n == 2'd2) begin
						// two octets stay held so the last buffer can
						// take up to the full limit
						emit = 1'b1;
						emit_b = s_q.hold0;
						allow_split = 1'b1; // [R07]
						s_d.hold0 = s_q.hold1;
						s_d.hold1 = rx_in.data;
					end else if (s_q.hold_n == 2'd1) begin
						s_d.hold1 = rx_in.data;
						s_d.hold_n = 2'd2;
					end else begin
						s_d.hold0 = rx_in.data;
						s_d.hold_n = 2'd1;
					end
				end
				if (rx_in.frame_end) begin
					s_d.err = rx_in.err;
					s_d.rx_st = LRS_FLUSH;
				end
			end
			LRS_FLUSH: begin
				if (s_q.hold_n != 2'd0) begin
					emit = 1'b1;
					emit_b = s_q.hold0;
					s_d.hold0 = s_q.hold1;
					s_d.hold_n = s_q.hold_n - 2'd1;
				end else begin
					is_err = (s_q.err != 8'h00);
					mask_ok = s_q.nonproto ?
						((s_q.err & ~s_q.nonproto_mask) == 8'h00) :
						((s_q.err & ~s_q.proto_mask) == 8'h00);
					s_d.frm.done = 1'b1;
					s_d.frm.count = s_q.oct_cnt;
					s_d.frm.short_f = (s_q.oct_cnt < minsz); // [R04]
					s_d.frm.long_f = s_q.long_f; // [R05]
					s_d.frm.err_rej = is_err &&
						!(s_q.error_accept_valid && mask_ok); // [R13]
					s_d.frm.accepted = (s_q.oct_cnt >= minsz) &&
						!(is_err && !(s_q.error_accept_valid && mask_ok));
					s_d.rx_st = LRS_IDLE;
				end
			end
			default: s_d.rx_st = LRS_IDLE;
		endcase

		// one octet written; first octet of a frame opens a buffer,
		// split mode opens another once limit minus two is filled
		if (emit) begin
			s_d.wr.valid = 1'b1;
			s_d.wr.data = emit_b;
			if (s_q.buf_cnt == 16'h0000 || (split && allow_split &&
				s_q.buf_cnt == {1'b0, s_q.max_info_length_value}
				- LRS_SPLIT_MARGIN)) begin
				s_d.wr.fetch = 1'b1; // [R07]
				s_d.buf_cnt = 16'h0001;
			end else begin
				s_d.buf_cnt = s_q.buf_cnt + 16'h0001;
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.max_info_length_value <= LRS_MAX_INFO_RST; // [R02]
			s_q.sent_reject_limit <= LRS_LIMIT_RST;
			s_q.sent_not_ready_limit <= LRS_LIMIT_RST;
			s_q.rx_st <= LRS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// outputs
	assign pready = 1'b1;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign buf_wr = s_q.wr;
	assign frame_res = s_q.frm;
	assign rx_pool = s_q.pool; // [R11]
	assign tx_next_ptr = s_q.tx_next;
	assign tx_ack_ptr = s_q.tx_ack;
	assign tx_len = s_q.tx_len;
	// chaining stops at the final link of the queue
	assign next_link_valid = !s_q.final_link_in_queue; // [R17]
	assign next_link_addr = s_q.next_link; // [R17]
	assign iq_post = s_q.iq_post;
	assign iq_code = s_q.iq_code;
endmodule

/* File: core/lrs_dummy_unused.sv */
`timescale 1ns/100ps
// ============================================================
// no logic here; the whole block lives in one design file

/* File: tb/lrs_link_rx_asserts.sv */
`timescale 1ns/100ps
// ============================================================
// port checker for the link receive block
module lrs_link_rx_chk (
	// clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// apb
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [31:0]  paddr,
	input wire logic [31:0]  pwdata,
	// receive
	input lrs_pkg::lrs_frm_t frame_res,
	input wire logic [12:0]  rx_pool,
	// transmit
	input wire logic         tx_acked,
	input wire logic [31:0]  tx_acked_ptr,
	input wire logic         tx_desc_load,
	input wire logic [15:0]  tx_desc_len,
	input wire logic [31:0]  tx_ack_ptr,
	input wire logic [15:0]  tx_len,
	// statistics
	input wire logic         rej_sent,
	input wire logic         rnr_sent,
	input wire logic         iq_post,
	input wire logic [1:0]   iq_code
);
	import lrs_pkg::*;
	logic wcyc;    // apb write access phase
	logic stats_q; // shadow of the statistics enable
	assign wcyc = psel && penable && pwrite;
	// shadow keeps the checker free of hierarchical peeks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stats_q <= 1'b0;
		end else if (wcyc && paddr == 32'h0000_0024) begin
			stats_q <= pwdata[0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_short;
		frame_res.done && frame_res.short_f |-> !frame_res.accepted;
	endproperty
	a_short: assert property (p_short) else $error("short accepted");
	property p_min;
		frame_res.done && frame_res.count < 16'h0005 |-> frame_res.short_f;
	endproperty
	a_min: assert property (p_min) else $error("tiny frame kept");
	property p_errrej;
		frame_res.done && frame_res.err_rej |-> !frame_res.accepted;
	endproperty
	a_errrej: assert property (p_errrej) else $error("bad frame kept");
	property p_pool;
		!(wcyc && paddr == 32'h0000_0004) |=> $stable(rx_pool);
	endproperty
	a_pool: assert property (p_pool) else $error("pool moved");
	property p_txlen;
		tx_desc_load |=> tx_len == $past(tx_desc_len);
	endproperty
	a_txlen: assert property (p_txlen) else $error("length lost");
	property p_txack;
		tx_acked && !wcyc |=> tx_ack_ptr == $past(tx_acked_ptr);
	endproperty
	a_txack: assert property (p_txack) else $error("ack ptr");
	property p_rejpost;
		iq_post && iq_code[0] |-> $past(rej_sent);
	endproperty
	a_rejpost: assert property (p_rejpost) else $error("rej post");
	property p_rnrpost;
		iq_post && iq_code[1] |-> $past(rnr_sent);
	endproperty
	a_rnrpost: assert property (p_rnrpost) else $error("rnr post");
	property p_stats;
		(rej_sent || rnr_sent) && !stats_q |=> !iq_post;
	endproperty
	a_stats: assert property (p_stats) else $error("stats off");
endmodule
bind lrs_link_rx lrs_link_rx_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .frame_res(frame_res), .rx_pool(rx_pool),
	.tx_acked(tx_acked), .tx_acked_ptr(tx_acked_ptr),
	.tx_desc_load(tx_desc_load), .tx_desc_len(tx_desc_len),
	.tx_ack_ptr(tx_ack_ptr), .tx_len(tx_len), .rej_sent(rej_sent),
	.rnr_sent(rnr_sent), .iq_post(iq_post), .iq_code(iq_code));

/* File: tb/lrs_frame_src.sv */
`timescale 1ns/100ps
// ============================================================
// deframer model: feeds octets between flags
module lrs_frame_src (
	// clock
	input wire logic         pclk,
	// octet stream
	output lrs_pkg::lrs_rx_t rx_in
);
	import lrs_pkg::*;
	initial rx_in = '0;
	// slow inserts an idle cycle after every step
	task automatic send(input int n, input logic num,
			input logic [7:0] e, input logic slow);
		lrs_rx_t v;
		lrs_rx_t idl;
		for (int i = 0; i <= n + 1; i++) begin
			v = '0;
			v.start = (i == 0);
			v.numbered = num; // frame class with start
			v.byte_valid = (i > 0) && (i <= n);
			v.data = v.byte_valid ? i[7:0] : ~rx_in.data;
			v.frame_end = (i == n + 1);
			v.err = v.frame_end ? e : ~rx_in.err;
			@(posedge pclk);
			rx_in <= v;
			if (slow) begin
				@(posedge pclk);
				idl = '0;
				idl.data = ~v.data; // idle data never repeats
				rx_in <= idl;
			end
		end
		@(posedge pclk);
		idl = '0;
		idl.data = ~rx_in.data;
		rx_in <= idl;
	endtask
endmodule

/* File: tb/lrs_link_rx_test.sv */
`timescale 1ns/100ps
// ============================================================
// register and frame tests for the link receive block
module lrs_link_rx_test;
	import lrs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rdv;
	logic [3:0]  pstrb;
	logic        last_err, slow, tx_advance, tx_acked, tx_desc_load;
	lrs_rx_t     rx_in;
	lrs_wr_t     buf_wr;
	lrs_frm_t    frame_res;
	logic [12:0] rx_pool;
	logic [31:0] tx_advance_ptr, tx_acked_ptr, tx_next_ptr, tx_ack_ptr;
	logic [15:0] tx_desc_len, tx_len;
	logic        next_link_valid, rej_sent, rnr_sent, iq_post;
	logic [31:0] next_link_addr;
	logic [1:0]  iq_code, code;
	int          err_count, checks, wr_n, fet_n, posts, ord_n;
	lrs_link_rx u_lrs_link_rx (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_in(rx_in), .buf_wr(buf_wr), .frame_res(frame_res),
		.rx_pool(rx_pool), .tx_advance(tx_advance),
		.tx_advance_ptr(tx_advance_ptr), .tx_acked(tx_acked),
		.tx_acked_ptr(tx_acked_ptr), .tx_desc_load(tx_desc_load),
		.tx_desc_len(tx_desc_len), .tx_next_ptr(tx_next_ptr),
		.tx_ack_ptr(tx_ack_ptr), .tx_len(tx_len),
		.next_link_valid(next_link_valid), .next_link_addr(next_link_addr),
		.rej_sent(rej_sent), .rnr_sent(rnr_sent), .iq_post(iq_post),
		.iq_code(iq_code));
	lrs_frame_src u_lrs_frame_src (.pclk(pclk), .rx_in(rx_in));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// tally buffer writes, fetches and queue posts
	always @(posedge pclk) begin
		if (buf_wr.valid === 1'b1) begin
			wr_n++;
			// octets must leave in the order the source numbered them
			if (buf_wr.data !== wr_n[7:0]) ord_n++;
		end
		if (buf_wr.valid === 1'b1 && buf_wr.fetch === 1'b1) fet_n++;
		if (iq_post === 1'b1) begin
			posts++;
			code = iq_code;
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic hang();
		err_count++;
		give_verdict();
	endtask
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h00_0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 16) hang();
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdv, e);
	endtask
	// limit only changes under local busy, host keeps it even
	task automatic link(input logic [31:0] mode, input logic [31:0] mx);
		wr(LRS_OFS_LINK_MODE, 32'h0000_0008);
		wr(LRS_OFS_MAX_INFO, mx);
		wr(LRS_OFS_LINK_MODE, mode);
	endtask
	// wn below zero skips the write tally for discarded frames
	task automatic rx(input int n, input logic num, input logic [7:0] e,
			input logic [3:0] f, input int wn, input int fn);
		int k;
		wr_n = 0;
		fet_n = 0;
		ord_n = 0;
		u_lrs_frame_src.send(n, num, e, slow);
		for (k = 0; k < 200; k++) begin
			@(posedge pclk);
			if (frame_res.done === 1'b1) break;
		end
		if (k == 200) hang();
		chk({frame_res.accepted, frame_res.short_f, frame_res.long_f,
			frame_res.err_rej, frame_res.count}, {f, n[15:0]});
		if (wn >= 0) chk({wr_n[15:0], fet_n[15:0], ord_n[7:0]},
			{wn[15:0], fn[15:0], 8'h00});
	endtask
	task automatic ev(input logic j, input logic r);
		@(posedge pclk);
		rej_sent <= j;
		rnr_sent <= r;
		@(posedge pclk);
		rej_sent <= 1'b0;
		rnr_sent <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, tx_advance_ptr} = '0;
		{tx_advance, tx_acked, tx_desc_load, tx_acked_ptr} = '0;
		{tx_desc_len, rej_sent, rnr_sent, slow, code} = '0;
		{err_count, checks, wr_n, fet_n, posts, ord_n} = '0;
		pstrb = 4'hF;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(LRS_OFS_MAX_INFO, 32'h0000_0104);
		wr(LRS_OFS_MAX_INFO, 32'h0000_8008);
		rd(LRS_OFS_MAX_INFO, 32'h0000_0008);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({last_err, rdv}, {1'b1, 32'h0000_0000});
		wr(LRS_OFS_POOL, 32'h0000_9FFF);
		rd(LRS_OFS_POOL, 32'h0000_9FFF);
		chk(rx_pool, 13'h1FFF);
		$display("test registers done");
		wr(LRS_OFS_POOL, 32'h0000_0003);
		link(32'h0000_0004, 32'h0000_0008);
		rx(4, 0, 0, 4'b0100, -1, 0);
		rx(5, 0, 0, 4'b1000, 5, 1);
		rx(5, 1, 0, 4'b0100, -1, 0);
		rx(6, 1, 0, 4'b1000, 6, 1);
		rx(17, 1, 0, 4'b1010, 14, 1);
		rx(6, 1, 8'h01, 4'b0001, -1, 0);
		wr(LRS_OFS_ERR_MASKS, 32'h0000_0001);
		wr(LRS_OFS_POOL, 32'h0000_8003);
		rx(6, 1, 8'h01, 4'b1000, 6, 1);
		rx(6, 1, 8'h02, 4'b0001, -1, 0);
		$display("test protocol frames done");
		link(32'h0000_0005, 32'h0000_0008);
		rx(10, 0, 0, 4'b1010, 8, 1);
		rx(4, 0, 0, 4'b0100, -1, 0);
		link(32'h0000_0007, 32'h0000_0008);
		rx(8, 0, 0, 4'b1000, 8, 1);
		slow = 1'b1;
		rx(20, 0, 0, 4'b1000, 20, 3);
		slow = 1'b0;
		$display("test buffer modes done");
		wr(LRS_OFS_QUEUE_HEAD, 32'h1234_5670);
		wr(LRS_OFS_COMMAND, 32'h0000_0001);
		rd(LRS_OFS_TX_NEXT, 32'h1234_5670);
		rd(LRS_OFS_TX_ACK, 32'h1234_5670);
		@(posedge pclk);
		{tx_advance, tx_acked, tx_desc_load} <= 3'b111;
		tx_advance_ptr <= 32'h1234_5680;
		tx_acked_ptr <= 32'h1234_5690;
		tx_desc_len <= 16'hFFFF;
		@(posedge pclk);
		{tx_advance, tx_acked, tx_desc_load} <= 3'b000;
		@(posedge pclk);
		chk(tx_next_ptr, 32'h1234_5680);
		chk(tx_ack_ptr, 32'h1234_5690);
		chk(tx_len, 16'hFFFF);
		wr(LRS_OFS_NEXT_LINK, 32'hABCD_0000);
		wr(LRS_OFS_LINK_MODE, 32'h0000_0000);
		@(posedge pclk);
		chk({next_link_valid, next_link_addr}, {1'b1, 32'hABCD_0000});
		wr(LRS_OFS_LINK_MODE, 32'h0000_0004);
		@(posedge pclk);
		chk(next_link_valid, 1'b0);
		$display("test transmit pointers done");
		wr(LRS_OFS_LIMITS, 32'h0000_0102);
		wr(LRS_OFS_OPTIONS2, 32'h0000_0001);
		// assignment takes the live limits, so reload the staged ones first
		wr(LRS_OFS_COMMAND, 32'h0000_0004);
		wr(LRS_OFS_COMMAND, 32'h0000_0002);
		rd(LRS_OFS_COUNTERS, 32'h0000_0102);
		ev(1'b1, 1'b0);
		ev(1'b1, 1'b0);
		chk({posts[7:0], code}, {8'h01, 2'b01});
		ev(1'b0, 1'b1);
		chk({posts[7:0], code}, {8'h02, 2'b10});
		wr(LRS_OFS_OPTIONS2, 32'h0000_0000);
		ev(1'b1, 1'b1);
		ev(1'b1, 1'b1);
		chk(posts, 2);
		rd(LRS_OFS_COUNTERS, 32'h0000_0102);
		wr(LRS_OFS_OPTIONS2, 32'h0000_0001);
		wr(LRS_OFS_LIMITS, 32'h0000_0103);
		wr(LRS_OFS_COMMAND, 32'h0000_0004);
		rd(LRS_OFS_LIMITS, 32'h0103_0103);
		rd(LRS_OFS_COUNTERS, 32'h0000_0102);
		ev(1'b1, 1'b0);
		ev(1'b1, 1'b0);
		rd(LRS_OFS_COUNTERS, 32'h0000_0103);
		chk(posts, 3);
		$display("test statistics done");
		give_verdict();
	end
endmodule
